// ### verilog/mcid_consts.vh
// Offsets, field positions, codes and reset values of the capability identification words
`ifndef MCID_CONSTS_VH
`define MCID_CONSTS_VH

// Byte offsets within the register window
`define MCID_ADDR_W 12
`define MCID_OFS_WORD0 12'h000
`define MCID_OFS_WORD1 12'h004

// First word field positions
`define MCID_W0_MATCH 27
`define MCID_W0_XOPS 26
`define MCID_W0_TFS 24
`define MCID_W0_IRQ 16
`define MCID_W0_EXG 15
`define MCID_W0_COHW 14
`define MCID_W0_BCAST 13
`define MCID_W0_SIDW 9
`define MCID_W0_EXID 8
`define MCID_W0_GRP 0

// Second word field positions
`define MCID_W1_PGSZ 31
`define MCID_W1_PNDX 28
`define MCID_W1_HWUP 24
`define MCID_W1_S2CB 16
`define MCID_W1_CONFL 15
`define MCID_W1_STP 12
`define MCID_W1_SSDW 8
`define MCID_W1_NCB 0

// Field codes and limits
`define MCID_CNT_MAX 8'h80
`define MCID_TFS_NONE 2'h2
`define MCID_TFS_RSVD 2'h3
`define MCID_HWUP_NONE 2'h0
`define MCID_HWUP_RSVD 2'h2
`define MCID_SIDW_EXT 4'hF
`define MCID_SSDT_FULL 2'h3
`define MCID_SSDW_FULL 4'hF

// Reset values
`define MCID_RDATA_RST 32'h00000000
`define MCID_WORD_RST 32'h00000000
`define MCID_CNT_RST 8'h00

`endif

// ### verilog/mcid_apb_ctrl.v
// APB transfer tracking, address decode and response for the identification words
`include "mcid_consts.vh"

module mcid_apb_ctrl (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // APB request
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   // Decode to the register bank
   output wire take,
   output wire sel_word0,
   output wire sel_word1,
   output reg err_flag,
   // APB handshake
   output wire pready
);

   localparam ST_IDLE = 2'b01;
   localparam ST_ACCESS = 2'b10;

   reg [1:0] state;
   reg [1:0] next_state;

   assign sel_word0 = (paddr == `MCID_OFS_WORD0);
   assign sel_word1 = (paddr == `MCID_OFS_WORD1);
   // Setup phase seen while idle; the bank captures its answer on this edge
   assign take = clk_en & psel & ~penable & state[0];
   // Zero wait states; a frozen clock enable stretches the access phase
   assign pready = clk_en & psel & penable & state[1];

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (pready) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         err_flag <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         if (take) begin
            // Writes to the words are dropped quietly; only unmapped addresses fail
            err_flag <= ~(sel_word0 | sel_word1);
         end
      end
   end

endmodule

// ### verilog/mcid_regs.v
// Capability identification words: build-time capabilities, security views, APB read port
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "mcid_consts.vh"

// Behaviour
// - Stream match support bit set means matching present, indexing absent.
// - Translation-operations-absent bit reads zero unless first stage is supported.
// - Two-bit table format field; reserved code 11 is never reported.
// - Context interrupt count field; non-secure readers see the configured count.
// - With extended matching built, group bit: secure 1, non-secure inverse disable.
// - Coherent walk bit reports coherent table walk support.
// - Broadcast maintenance bit reports broadcast cache maintenance support.
// - Stream identifier width field 0-15, reads 15 when extended identifiers exist.
// - Extended identifier bit set means 16-bit identifiers and width field 15.
// - Map group count 0-128; non-secure readers see the configured group count.
// - With extended matching built, secure group count reads 128.
// - Page size bit: 0 means 4KB pages, 1 means 64KB pages.
// - Three-bit page index width n; each space spans 2^(n+1) pages.
// - Hardware flag update field; reserved code 10 is never reported.
// - Stage-two-only bank count 0-128, meaningful only with second stage.
// - Conflict detection bit set only when detection is guaranteed.
// - Security table presence field reads zero for non-secure readers.
// - Security table index width forced to 1111 when presence is 11; non-secure zero.
// - Total bank count 0-128 includes stage-two-only banks; difference gives stage one.
// - Non-secure readers see the configured bank count in the total field.
// - Both words are 32-bit read-only; secure contents fixed by the build, non-secure interrupt, group and total bank counts taken from the configuration inputs.
module mcid_regs #(
   parameter [0:0] TWO_SEC_STATES = 1'b1,
   parameter [0:0] EXT_MATCH_BUILT = 1'b0,
   parameter [0:0] STREAM_MATCH = 1'b1,
   parameter [0:0] FIRST_STAGE = 1'b1,
   parameter [0:0] SECOND_STAGE = 1'b1,
   parameter [0:0] XLATE_OPS_ABSENT = 1'b0,
   parameter [1:0] TABLE_FORMAT = 2'h0,
   parameter [7:0] CTX_IRQ_COUNT = 8'h08,
   parameter [0:0] COHERENT_WALK = 1'b1,
   parameter [0:0] BROADCAST_MAINT = 1'b0,
   parameter [3:0] STREAM_ID_WIDTH = 4'h8,
   parameter [0:0] EXT_STREAM_ID = 1'b0,
   parameter [7:0] MAP_GROUPS = 8'h20,
   parameter [0:0] REG_PAGE_64K = 1'b0,
   parameter [2:0] PAGE_INDEX_WIDTH = 3'h3,
   parameter [1:0] HW_FLAG_UPDATE = 2'h0,
   parameter [7:0] STAGE2_ONLY_BANKS = 8'h04,
   parameter [0:0] CONFLICT_DETECT = 1'b0,
   parameter [1:0] SEC_TABLE_PRESENT = 2'h1,
   parameter [3:0] SEC_TABLE_INDEX_WIDTH = 4'h6,
   parameter [7:0] TOTAL_BANKS = 8'h10
) (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [2:0] pprot,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Non-secure view settings from the secure configuration words
   input wire [7:0] nonsec_irq_count_cfg,
   input wire [7:0] nonsec_group_count_cfg,
   input wire [7:0] nonsec_bank_count_cfg,
   input wire nonsec_ext_group_disable,
   // Derived capability for the translation logic
   output reg [7:0] stage1_bank_count,
   output reg ext_group_nonsec_visible
);

   // Field placement helpers
   function [31:0] place8;
      input [7:0] v;
      input integer pos;
      begin
         place8 = {24'h000000, v} << pos;
      end
   endfunction

   function [31:0] place4;
      input [3:0] v;
      input integer pos;
      begin
         place4 = {28'h0000000, v} << pos;
      end
   endfunction

   function [31:0] place2;
      input [1:0] v;
      input integer pos;
      begin
         place2 = {30'h00000000, v} << pos;
      end
   endfunction

   function [31:0] place1;
      input v;
      input integer pos;
      begin
         place1 = {31'h00000000, v} << pos;
      end
   endfunction

   // Counts above the architectural range are held at the top of the range
   function [7:0] clamp_count;
      input [7:0] v;
      begin
         if (v > `MCID_CNT_MAX) begin
            clamp_count = `MCID_CNT_MAX;
         end else begin
            clamp_count = v;
         end
      end
   endfunction

   // Capability fields after consistency fixes
   wire cap_stream_match;
   wire cap_xlate_absent;
   wire [1:0] cap_table_format;
   wire [7:0] cap_irq_count;
   wire cap_coherent_walk;
   wire cap_broadcast_maint;
   wire [3:0] cap_sid_width;
   wire cap_ext_sid;
   wire [7:0] cap_groups;
   wire cap_page_64k;
   wire [2:0] cap_page_index;
   wire [1:0] cap_hw_update;
   wire [7:0] cap_s2_banks;
   wire cap_conflict;
   wire [1:0] cap_sec_table;
   wire [3:0] cap_sec_index;
   wire [7:0] cap_total_banks;

   assign cap_stream_match = STREAM_MATCH;
   assign cap_xlate_absent = XLATE_OPS_ABSENT & FIRST_STAGE;
   // A reserved format code is reported as no table format at all
   assign cap_table_format = (TABLE_FORMAT == `MCID_TFS_RSVD) ?
                             `MCID_TFS_NONE : TABLE_FORMAT;
   assign cap_irq_count = CTX_IRQ_COUNT;
   assign cap_coherent_walk = COHERENT_WALK;
   assign cap_broadcast_maint = BROADCAST_MAINT;
   assign cap_ext_sid = EXT_STREAM_ID;
   assign cap_sid_width = EXT_STREAM_ID ? `MCID_SIDW_EXT : STREAM_ID_WIDTH;
   // Secure count is fixed once extended matching is built
   assign cap_groups = EXT_MATCH_BUILT ? `MCID_CNT_MAX : clamp_count(MAP_GROUPS);
   assign cap_page_64k = REG_PAGE_64K;
   assign cap_page_index = PAGE_INDEX_WIDTH;
   assign cap_hw_update = (HW_FLAG_UPDATE == `MCID_HWUP_RSVD) ?
                          `MCID_HWUP_NONE : HW_FLAG_UPDATE;
   // Without a second stage the stage-two-only count carries no meaning; zero it
   assign cap_s2_banks = SECOND_STAGE ? clamp_count(STAGE2_ONLY_BANKS) : `MCID_CNT_RST;
   assign cap_conflict = CONFLICT_DETECT;
   assign cap_sec_table = SEC_TABLE_PRESENT;
   assign cap_sec_index = (SEC_TABLE_PRESENT == `MCID_SSDT_FULL) ?
                          `MCID_SSDW_FULL : SEC_TABLE_INDEX_WIDTH;
   assign cap_total_banks = clamp_count(TOTAL_BANKS);

   // Secure view of both words
   wire [31:0] sec_word0;
   wire [31:0] sec_word1;

   assign sec_word0 = place1(cap_stream_match, `MCID_W0_MATCH) |
                      place1(cap_xlate_absent, `MCID_W0_XOPS) |
                      place2(cap_table_format, `MCID_W0_TFS) |
                      place8(cap_irq_count, `MCID_W0_IRQ) |
                      place1(EXT_MATCH_BUILT, `MCID_W0_EXG) |
                      place1(cap_coherent_walk, `MCID_W0_COHW) |
                      place1(cap_broadcast_maint, `MCID_W0_BCAST) |
                      place4(cap_sid_width, `MCID_W0_SIDW) |
                      place1(cap_ext_sid, `MCID_W0_EXID) |
                      place8(cap_groups, `MCID_W0_GRP);

   assign sec_word1 = place1(cap_page_64k, `MCID_W1_PGSZ) |
                      place4({1'b0, cap_page_index}, `MCID_W1_PNDX) |
                      place2(cap_hw_update, `MCID_W1_HWUP) |
                      place8(cap_s2_banks, `MCID_W1_S2CB) |
                      place1(cap_conflict, `MCID_W1_CONFL) |
                      place2(cap_sec_table, `MCID_W1_STP) |
                      place4(cap_sec_index, `MCID_W1_SSDW) |
                      place8(cap_total_banks, `MCID_W1_NCB);

   // Non-secure view: interrupt, group and total bank counts come from the secure configuration settings
   wire ns_ext_group;
   wire [31:0] ns_word0;
   wire [31:0] ns_word1;

   assign ns_ext_group = EXT_MATCH_BUILT & ~nonsec_ext_group_disable;

   assign ns_word0 = place1(cap_stream_match, `MCID_W0_MATCH) |
                     place1(cap_xlate_absent, `MCID_W0_XOPS) |
                     place2(cap_table_format, `MCID_W0_TFS) |
                     place8(nonsec_irq_count_cfg, `MCID_W0_IRQ) |
                     place1(ns_ext_group, `MCID_W0_EXG) |
                     place1(cap_coherent_walk, `MCID_W0_COHW) |
                     place1(cap_broadcast_maint, `MCID_W0_BCAST) |
                     place4(cap_sid_width, `MCID_W0_SIDW) |
                     place1(cap_ext_sid, `MCID_W0_EXID) |
                     place8(nonsec_group_count_cfg, `MCID_W0_GRP);

   // Security table fields are left at zero for non-secure readers
   assign ns_word1 = place1(cap_page_64k, `MCID_W1_PGSZ) |
                     place4({1'b0, cap_page_index}, `MCID_W1_PNDX) |
                     place2(cap_hw_update, `MCID_W1_HWUP) |
                     place8(cap_s2_banks, `MCID_W1_S2CB) |
                     place1(cap_conflict, `MCID_W1_CONFL) |
                     place8(nonsec_bank_count_cfg, `MCID_W1_NCB);

   // APB side
   wire take;
   wire sel_word0;
   wire sel_word1;
   wire err_flag;
   wire reader_ns;
   reg [31:0] next_prdata;

   mcid_apb_ctrl u_ctrl (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .take(take),
      .sel_word0(sel_word0),
      .sel_word1(sel_word1),
      .err_flag(err_flag),
      .pready(pready)
   );

   // A single-state build has only the secure view
   assign reader_ns = TWO_SEC_STATES & pprot[1];
   assign pslverr = pready & err_flag;

   // Read data is chosen in the setup phase so the access phase needs no wait state
   always @* begin
      next_prdata = `MCID_RDATA_RST;
      if (!pwrite) begin
         if (sel_word0) begin
            next_prdata = reader_ns ? ns_word0 : sec_word0;
         end else if (sel_word1) begin
            next_prdata = reader_ns ? ns_word1 : sec_word1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `MCID_RDATA_RST;
      end else if (clk_en & take) begin
         // Write data is never stored: the words have no storage behind them
         prdata <= next_prdata;
      end
   end

   // Stage-one-capable banks for the translation logic, secure view
   wire [7:0] s1_count;

   assign s1_count = (cap_total_banks > cap_s2_banks) ?
                     (cap_total_banks - cap_s2_banks) : `MCID_CNT_RST;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1_bank_count <= `MCID_CNT_RST;
         ext_group_nonsec_visible <= 1'b0;
      end else if (clk_en) begin
         stage1_bank_count <= FIRST_STAGE ? s1_count : `MCID_CNT_RST;
         ext_group_nonsec_visible <= ns_ext_group;
      end
   end

endmodule

// ### tb/mcid_regs_checker.sv
// Concurrent checks on the identification word register port
module mcid_regs_checker #(
   parameter [0:0] EXT_MATCH_BUILT = 1'b0
) (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [2:0] pprot,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Non-secure view
   input wire [7:0] nonsec_irq_count_cfg,
   input wire [7:0] nonsec_group_count_cfg,
   input wire [7:0] nonsec_bank_count_cfg,
   input wire nonsec_ext_group_disable,
   input wire ext_group_nonsec_visible
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup = psel & !penable & clk_en;
   wire rd_ns = pready & !pwrite & pprot[1];
   wire mapped = (paddr == 12'h000) | (paddr == 12'h004);

   a_zero_wait: assert property (setup ##1 (psel && penable && clk_en) |-> pready)
      else $error("no answer in the access cycle");
   a_unmapped_err: assert property (setup && !mapped ##1 pready |-> pslverr)
      else $error("unmapped address not refused");
   a_mapped_ok: assert property (setup && mapped ##1 pready |-> !pslverr)
      else $error("mapped word answered with error");
   a_err_in_ready: assert property (pslverr |-> pready)
      else $error("error outside access completion");
   a_idle_quiet: assert property (!(psel && penable) |-> !pready)
      else $error("ready outside access phase");
   a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("write returned data");
   a_ns_word0: assert property (rd_ns && paddr == 12'h000 |->
      prdata[23:16] == $past(nonsec_irq_count_cfg)
      && prdata[7:0] == $past(nonsec_group_count_cfg))
      else $error("non-secure word0 counts wrong");
   a_ns_word1: assert property (rd_ns && paddr == 12'h004 |->
      prdata[13:0] == {6'h00, $past(nonsec_bank_count_cfg)})
      else $error("non-secure word1 view wrong");
   a_ext_visible: assert property (clk_en |=> ext_group_nonsec_visible ==
      (EXT_MATCH_BUILT & !$past(nonsec_ext_group_disable)))
      else $error("extended group visibility wrong");
endmodule

bind mcid_regs mcid_regs_checker #(.EXT_MATCH_BUILT(EXT_MATCH_BUILT)) u_chk (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pprot(pprot), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .nonsec_irq_count_cfg(nonsec_irq_count_cfg),
   .nonsec_group_count_cfg(nonsec_group_count_cfg),
   .nonsec_bank_count_cfg(nonsec_bank_count_cfg),
   .nonsec_ext_group_disable(nonsec_ext_group_disable),
   .ext_group_nonsec_visible(ext_group_nonsec_visible));

// ### tb/mcid_regs_tb.sv
// Self-checking bench for the identification words
module mcid_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, ns_dis = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] pprot = 3'h0;
   logic [7:0] irq_cfg = 8'h05, grp_cfg = 8'h11, bank_cfg = 8'h07;
   wire [31:0] prdata;
   wire pready, pslverr, ext_vis;
   wire [7:0] s1_banks;
   int n_errors = 0;
   int samples_checked = 0;

   // Reserved codes in table format and flag update ask the sanitising logic;
   // extended matching, extended identifiers and full security table presence are built; the rest keep defaults
   mcid_regs #(.EXT_MATCH_BUILT(1'b1), .TABLE_FORMAT(2'h3), .HW_FLAG_UPDATE(2'h2),
      .EXT_STREAM_ID(1'b1), .SEC_TABLE_PRESENT(2'h3)) uut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nonsec_irq_count_cfg(irq_cfg),
      .nonsec_group_count_cfg(grp_cfg), .nonsec_bank_count_cfg(bank_cfg),
      .nonsec_ext_group_disable(ns_dis), .stage1_bank_count(s1_banks),
      .ext_group_nonsec_visible(ext_vis));

   always #10 pclk = ~pclk;

   function automatic [31:0] w0(input ns);
      w0 = {4'h0, 1'b1, 1'b0, 2'h2, ns ? irq_cfg : 8'h08, ns ? !ns_dis : 1'b1,
         1'b1, 1'b0, 4'hF, 1'b1, ns ? grp_cfg : 8'h80};
   endfunction

   function automatic [31:0] w1(input ns);
      w1 = {1'b0, 3'h3, 2'h0, 2'h0, 8'h04, 1'b0, 1'b0, ns ? 6'h00 : 6'h3F,
         ns ? bank_cfg : 8'h10};
   endfunction

   task automatic check(input [31:0] got, input [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (n_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Leaves psel high so a following call makes a back-to-back transfer
   task automatic apb(input [11:0] a, input w, input ns, input int gap,
      output [31:0] d, output e);
      int n;
      n = 0;
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pprot <= {1'b0, ns, 1'b0};
      pwdata <= 32'hFFFFFFFF;
      @(posedge pclk);
      penable <= 1;
      if (gap > 0) clk_en <= 0;
      repeat (gap) begin
         @(posedge pclk);
         check(pready, 1'b0);
      end
      if (gap > 0) clk_en <= 1;
      forever begin
         @(posedge pclk);
         if (pready === 1'b1) break;
         n++;
         if (n > 20) begin
            check(pready, 1'b1);
            break;
         end
      end
      d = prdata;
      e = pslverr;
   endtask

   task automatic idle();
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask

   task automatic t_reset();
      repeat (12) @(posedge pclk);
      check(prdata, 32'h0);
      check({pready, pslverr, ext_vis, s1_banks}, 32'h0);
      presetn <= 1;
      repeat (2) @(posedge pclk);
      check(s1_banks, 8'h0C);
   endtask

   task automatic t_secure();
      logic [31:0] d;
      logic e;
      apb(12'h000, 0, 0, 0, d, e);
      check(d, w0(0));
      check(e, 1'b0);
      apb(12'h004, 0, 0, 0, d, e);
      check(d, w1(0));
      idle();
   endtask

   task automatic t_nonsec();
      logic [31:0] d;
      logic e;
      for (int i = 0; i < 2; i++) begin
         ns_dis <= i[0];
         irq_cfg <= 8'h05 + i[7:0];
         repeat (2) @(posedge pclk);
         check(ext_vis, !i[0]);
         apb(12'h000, 0, 1, 0, d, e);
         check(d, w0(1));
         apb(12'h004, 0, 1, 0, d, e);
         check(d, w1(1));
         idle();
      end
   endtask

   task automatic t_write_err();
      logic [31:0] d;
      logic e;
      apb(12'h000, 1, 0, 0, d, e);
      check(e, 1'b0);
      apb(12'h004, 1, 1, 0, d, e);
      check(e, 1'b0);
      apb(12'h000, 0, 0, 0, d, e);
      check(d, w0(0));
      apb(12'h008, 0, 0, 0, d, e);
      check(d, 32'h0);
      check(e, 1'b1);
      apb(12'hFFC, 1, 0, 0, d, e);
      check(e, 1'b1);
      apb(12'h004, 0, 0, 3, d, e);
      check(d, w1(0));
      idle();
   endtask

   initial begin
      #50000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      t_reset();
      t_secure();
      t_nonsec();
      t_write_err();
      report_and_stop();
   end
endmodule
